// [logic/lprc_ctrl.sv]
// Low power run mode controller with register port and reset vector fetch
//
// Contract
// - After reset, start address is fetched from the vector at 0xFFFE-0xFFFF.
// - Setting the request bit enters low power run; regulator goes to standby.
// - Software clears detect enables; device disables detect and warning in low power.
// - Entry is refused while the processor is halted in background debug.
// - Clearing the request bit returns to run with full regulation.
// - Read-only standby status bit: a software exit clears it once full_sync is set; a debug pin or wake interrupt exit clears it at once.
// - With wake option set, an interrupt clears both bits and restores regulation.
// - With wake option clear, interrupts are served staying in low power run.
// - Any reset leaves low power run and clears request and status bits.
// - Debug pin falling edge in low power run returns to normal run.
// - Debug pin falling edge in low power wait returns to normal run.
// - Wait instruction in low power run enters low power wait, regulator standby.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lprc_ctrl
  import lprc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core events
  input wire logic bdm_active,
  input wire logic irq_pending,
  input wire logic wait_exec,
  // Debug pin, asynchronous
  input wire logic debug_pin,
  // Regulator
  input wire logic reg_full_ok,
  output logic reg_standby_req,
  // Mode and detector gating
  output logic [1:0] mode,
  output logic low_voltage_detect_active,
  output logic low_voltage_warning_active,
  // Reset vector fetch
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] start_addr,
  output logic start_valid
);

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic rst_meta;
  logic rst_n;
  logic dbg_meta;
  logic dbg_sync;
  logic dbg_prev;
  logic full_meta;
  logic full_sync;
  logic dbg_fall;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbg_meta <= 1'b1;
      dbg_sync <= 1'b1;
      dbg_prev <= 1'b1;
      full_meta <= 1'b1;
      full_sync <= 1'b1;
    end
    else
    begin
      dbg_meta <= debug_pin;
      dbg_sync <= dbg_meta;
      dbg_prev <= dbg_sync;
      full_meta <= reg_full_ok;
      full_sync <= full_meta;
    end
  end

  assign dbg_fall = dbg_prev & ~dbg_sync;

  // ****************************************
  // Register write decode
  // ****************************************
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_pmc;
  logic wr_lv;

  assign wr_pmc = reg_wr & hit(reg_addr, OFS_POWER_MODE_CONTROL_TWO);
  assign wr_lv = reg_wr & hit(reg_addr, OFS_LV_CONFIG);

  // ****************************************
  // Mode sequencing
  // ****************************************
  lprc_mode_t state;
  lprc_mode_t next_state;
  logic low_power_request;
  logic next_low_power_request;
  logic wake_full_reg_on_irq;
  logic force_exit;

  // Hardware exits that drop both bits at once
  assign force_exit = (state != MODE_RUN)
    && (dbg_fall || (irq_pending && wake_full_reg_on_irq));

  always_comb
  begin
    next_state = state;
    next_low_power_request = low_power_request;
    case (state)
      MODE_RUN:
      begin
        if (wr_pmc && reg_wdata[BIT_LOW_POWER_REQUEST] && !bdm_active)
        begin
          next_state = MODE_LP_RUN;
          next_low_power_request = 1'b1;
        end
      end
      MODE_LP_RUN:
      begin
        if (force_exit)
        begin
          next_state = MODE_RUN;
          next_low_power_request = 1'b0;
        end
        else if (wr_pmc && !reg_wdata[BIT_LOW_POWER_REQUEST])
        begin
          next_state = MODE_RUN;
          next_low_power_request = 1'b0;
        end
        else if (wait_exec)
          next_state = MODE_LP_WAIT;
      end
      MODE_LP_WAIT:
      begin
        if (force_exit)
        begin
          next_state = MODE_RUN;
          next_low_power_request = 1'b0;
        end
        else if (irq_pending)
          next_state = MODE_LP_RUN;
      end
      default:
      begin
        next_state = MODE_RUN;
        next_low_power_request = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= MODE_RUN;
      mode <= MODE_RUN;
      low_power_request <= RST_LOW_POWER_REQUEST;
    end
    else
    begin
      state <= next_state;
      mode <= next_state;
      low_power_request <= next_low_power_request;
    end
  end

  // Wake option bit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wake_full_reg_on_irq <= RST_WAKE_FULL_REG_ON_IRQ;
    else if (wr_pmc)
      wake_full_reg_on_irq <= reg_wdata[BIT_WAKE_FULL_REG_ON_IRQ];
  end

  // ****************************************
  // Regulator control and status
  // ****************************************
  logic regulator_standby_status;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_standby_req <= 1'b0;
    else
      reg_standby_req <= (next_state != MODE_RUN);
  end

  // Status lags a software exit until the regulator reports full
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      regulator_standby_status <= RST_REGULATOR_STANDBY_STATUS;
    else if (next_state != MODE_RUN)
      regulator_standby_status <= 1'b1;
    else if (force_exit)
      regulator_standby_status <= 1'b0;
    else if (!reg_standby_req && full_sync)
      regulator_standby_status <= 1'b0;
  end

  // ****************************************
  // Detector gating
  // ****************************************
  logic [2:0] lv_config;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lv_config <= RST_LV_CONFIG;
    else if (wr_lv)
      lv_config <= reg_wdata[2:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_voltage_detect_active <= 1'b0;
      low_voltage_warning_active <= 1'b0;
    end
    else
    begin
      low_voltage_detect_active <= lv_config[BIT_LVD_ENABLE] && (next_state == MODE_RUN);
      low_voltage_warning_active <= lv_config[BIT_LVW_ENABLE] && (next_state == MODE_RUN);
    end
  end

  // ****************************************
  // Reset vector fetch
  // ****************************************
  lprc_vfetch_t vf;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vf <= VF_HIGH;
      mem_addr <= VEC_ADDR_HIGH;
      mem_rd <= 1'b0;
      start_addr <= RST_START_ADDR;
      start_valid <= 1'b0;
    end
    else
    begin
      case (vf)
        VF_HIGH:
        begin
          mem_addr <= VEC_ADDR_HIGH;
          mem_rd <= 1'b1;
          vf <= VF_HIGH_DATA;
        end
        VF_HIGH_DATA:
        begin
          mem_addr <= VEC_ADDR_LOW;
          mem_rd <= 1'b1;
          vf <= VF_LOW;
        end
        VF_LOW:
        begin
          start_addr[15:8] <= mem_rdata;
          mem_rd <= 1'b0;
          vf <= VF_LOW_DATA;
        end
        VF_LOW_DATA:
        begin
          start_addr[7:0] <= mem_rdata;
          start_valid <= 1'b1;
          vf <= VF_DONE;
        end
        VF_DONE:
          mem_rd <= 1'b0;
        default:
        begin
          vf <= VF_HIGH;
          mem_rd <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      OFS_POWER_MODE_CONTROL_TWO:
      begin
        next_rdata[BIT_LOW_POWER_REQUEST] = low_power_request;
        next_rdata[BIT_REGULATOR_STANDBY_STATUS] = regulator_standby_status;
        next_rdata[BIT_WAKE_FULL_REG_ON_IRQ] = wake_full_reg_on_irq;
      end
      OFS_LV_CONFIG:
        next_rdata[2:0] = lv_config;
      OFS_MODE_STATUS:
        next_rdata[1:0] = state;
      OFS_START_ADDR:
        next_rdata = start_addr[15:8];
      default:
        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
  end

endmodule
`default_nettype wire

// [logic/lprc_pkg.sv]
// Shared constants and types for the low power run mode controller
package lprc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFS_POWER_MODE_CONTROL_TWO = 4'h0;
  localparam logic [3:0] OFS_LV_CONFIG = 4'h1;
  localparam logic [3:0] OFS_MODE_STATUS = 4'h2;
  localparam logic [3:0] OFS_START_ADDR = 4'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_LOW_POWER_REQUEST = 0;
  localparam int BIT_REGULATOR_STANDBY_STATUS = 1;
  localparam int BIT_WAKE_FULL_REG_ON_IRQ = 2;
  localparam int BIT_LVD_ENABLE = 0;
  localparam int BIT_LVD_STOP_ENABLE = 1;
  localparam int BIT_LVW_ENABLE = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_LOW_POWER_REQUEST = 1'b0;
  localparam logic RST_REGULATOR_STANDBY_STATUS = 1'b0;
  localparam logic RST_WAKE_FULL_REG_ON_IRQ = 1'b0;
  localparam logic [2:0] RST_LV_CONFIG = 3'h0;
  localparam logic [15:0] RST_START_ADDR = 16'h0000;

  // ****************************************
  // Reset vector location
  // ****************************************
  localparam logic [15:0] VEC_ADDR_HIGH = 16'hfffe;
  localparam logic [15:0] VEC_ADDR_LOW = 16'hffff;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [1:0]
  {
    MODE_RUN = 2'b00,
    MODE_LP_RUN = 2'b01,
    MODE_LP_WAIT = 2'b10
  } lprc_mode_t;

  // Vector fetch sequence
  typedef enum logic [2:0]
  {
    VF_HIGH = 3'b000,
    VF_HIGH_DATA = 3'b001,
    VF_LOW = 3'b010,
    VF_LOW_DATA = 3'b011,
    VF_DONE = 3'b100
  } lprc_vfetch_t;

endpackage

// [testbench/lprc_ctrl_checker.sv]
// Port-level assertions for the low power run mode controller
`timescale 1ns/1ps
`default_nettype none
module lprc_ctrl_checker
  import lprc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core events and outputs
  input wire logic bdm_active,
  input wire logic irq_pending,
  input wire logic wait_exec,
  input wire logic reg_standby_req,
  input wire logic [1:0] mode,
  input wire logic low_voltage_detect_active,
  input wire logic low_voltage_warning_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic wake;
  // Shadow of the wake option bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      wake <= 1'b0;
    else if (reg_wr && reg_addr == OFS_POWER_MODE_CONTROL_TWO)
      wake <= reg_wdata[BIT_WAKE_FULL_REG_ON_IRQ];
  end
  sequence s_ctl_wr;
    reg_wr && reg_addr == OFS_POWER_MODE_CONTROL_TWO;
  endsequence
  sequence s_lp_irq;
    mode == MODE_LP_RUN && irq_pending && !reg_wr && !wait_exec;
  endsequence
  lp_entry_a: assert property ((mode == MODE_RUN && !bdm_active && reg_wdata[0]) ##0 s_ctl_wr
    |=> mode == MODE_LP_RUN && reg_standby_req) else $error("entry missed");
  bdm_refuse_a: assert property ((mode == MODE_RUN && bdm_active) ##0 s_ctl_wr
    |=> mode == MODE_RUN && !reg_standby_req) else $error("entry not refused");
  sw_exit_a: assert property ((mode == MODE_LP_RUN && !irq_pending && !reg_wdata[0]) ##0 s_ctl_wr
    |=> mode == MODE_RUN && !reg_standby_req) else $error("exit missed");
  irq_wake_a: assert property (s_lp_irq ##0 wake
    |=> mode == MODE_RUN && !reg_standby_req) else $error("wake exit missed");
  irq_stay_a: assert property (s_lp_irq ##0 !wake
    |=> mode == MODE_LP_RUN && reg_standby_req) else $error("left low power on irq");
  wait_entry_a: assert property (mode == MODE_LP_RUN && wait_exec && !irq_pending && !reg_wr
    |=> mode == MODE_LP_WAIT && reg_standby_req) else $error("wait entry missed");
  lv_gate_a: assert property ((mode != MODE_RUN)[*2]
    |-> !low_voltage_detect_active && !low_voltage_warning_active) else $error("detector on");
  status_hold_a: assert property (reg_rd && reg_addr == OFS_POWER_MODE_CONTROL_TWO && reg_standby_req
    |=> reg_rdata[BIT_REGULATOR_STANDBY_STATUS]) else $error("status low in standby");
endmodule
bind lprc_ctrl lprc_ctrl_checker u_chk (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .bdm_active, .irq_pending, .wait_exec, .reg_standby_req, .mode,
  .low_voltage_detect_active, .low_voltage_warning_active);
`default_nettype wire

// [testbench/lprc_ctrl_test.sv]
// Self-checking testbench for the low power run mode controller
`timescale 1ns/1ps
`default_nettype none
module lprc_ctrl_test
  import lprc_pkg::*;
;
  typedef struct {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] r; logic lv; logic lw;} lprc_row_t;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic bdm_active = 1'b0;
  logic irq_pending = 1'b0;
  logic wait_exec = 1'b0;
  logic debug_pin = 1'b1;
  logic reg_full_ok = 1'b1;
  logic reg_standby_req;
  logic [1:0] mode;
  logic low_voltage_detect_active;
  logic low_voltage_warning_active;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata = 8'h00;
  logic [15:0] start_addr;
  logic start_valid;
  int n_errors = 0;
  int total_checks = 0;
  lprc_row_t rows [10] = '{
    '{4'h1, 1'b1, 8'h07, 8'h07, 1'b1, 1'b1}, '{4'h1, 1'b1, 8'h05, 8'h05, 1'b1, 1'b1},
    '{4'h1, 1'b1, 8'h02, 8'h02, 1'b0, 1'b0}, '{4'h1, 1'b1, 8'h04, 8'h04, 1'b0, 1'b1},
    '{4'h0, 1'b1, 8'h02, 8'h00, 1'b0, 1'b1}, '{4'h0, 1'b1, 8'h04, 8'h04, 1'b0, 1'b1},
    '{4'h0, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1}, '{4'h9, 1'b1, 8'hff, 8'h00, 1'b0, 1'b1},
    '{4'h2, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1}, '{4'h3, 1'b0, 8'h00, 8'hc1, 1'b0, 1'b1}};
  lprc_ctrl u_lprc_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bdm_active(bdm_active), .irq_pending(irq_pending), .wait_exec(wait_exec),
    .debug_pin(debug_pin), .reg_full_ok(reg_full_ok), .reg_standby_req(reg_standby_req),
    .mode(mode), .low_voltage_detect_active(low_voltage_detect_active),
    .low_voltage_warning_active(low_voltage_warning_active), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .start_addr(start_addr), .start_valid(start_valid));
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Vector memory and regulator stand-ins
  always @(posedge clk_sys)
  begin
    mem_rdata <= (mem_addr == VEC_ADDR_HIGH) ? 8'hc1 : 8'h3a;
    reg_full_ok <= !reg_standby_req;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic ev(input logic i, input logic w);
    @(posedge clk_sys);
    irq_pending <= i;
    wait_exec <= w;
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    wait_exec <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (20) if (start_valid !== 1'b1) @(posedge clk_sys);
    #1;
    chk(start_valid, 1'b1);
    chk(start_addr, 16'hc13a);
    chk(mem_addr, VEC_ADDR_LOW);
    chk(mem_rd, 1'b0);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
      chk(low_voltage_detect_active, rows[i].lv);
      chk(low_voltage_warning_active, rows[i].lw);
    end
    // Entry refused under debug halt
    bdm_active <= 1'b1;
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h01);
    chk(mode, MODE_RUN);
    bdm_active <= 1'b0;
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h00);
    // Entry, status, software exit with lagging status
    wr(OFS_LV_CONFIG, 8'h05);
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h01);
    chk({mode, reg_standby_req}, {MODE_LP_RUN, 1'b1});
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h03);
    chk({low_voltage_detect_active, low_voltage_warning_active}, 2'b00);
    rd(OFS_MODE_STATUS, 8'h01);
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h00);
    chk({mode, reg_standby_req}, {MODE_RUN, 1'b0});
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h02);
    repeat (6) @(posedge clk_sys);
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h00);
    // Interrupts with wake option clear, then set
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h01);
    ev(1'b1, 1'b0);
    chk({mode, reg_standby_req}, {MODE_LP_RUN, 1'b1});
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h05);
    ev(1'b1, 1'b0);
    chk({mode, reg_standby_req}, {MODE_RUN, 1'b0});
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h04);
    // Wait ignored in run, low power wait, debug pin exits
    ev(1'b0, 1'b1);
    chk(mode, MODE_RUN);
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h01);
    ev(1'b0, 1'b1);
    chk({mode, reg_standby_req}, {MODE_LP_WAIT, 1'b1});
    ev(1'b1, 1'b0);
    chk(mode, MODE_LP_RUN);
    ev(1'b0, 1'b1);
    debug_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk({mode, reg_standby_req}, {MODE_RUN, 1'b0});
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h00);
    debug_pin <= 1'b1;
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h01);
    repeat (3) @(posedge clk_sys);
    debug_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk({mode, reg_standby_req}, {MODE_RUN, 1'b0});
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h00);
    debug_pin <= 1'b1;
    // Reset in mid low power run
    wr(OFS_POWER_MODE_CONTROL_TWO, 8'h05);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({mode, reg_standby_req}, {MODE_RUN, 1'b0});
    chk(start_valid, 1'b0);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(OFS_POWER_MODE_CONTROL_TWO, 8'h00);
    chk(start_valid, 1'b1);
    chk(start_addr, 16'hc13a);
    summarize();
  end
endmodule
`default_nettype wire
